/* fvrc_map.svh */
// Offsets, field positions, reset values and timing counts of the flash config link
`ifndef FVRC_MAP_SVH
`define FVRC_MAP_SVH

// ----------------------------------------------------------------
// Serial command codes
// ----------------------------------------------------------------
`define FVRC_CMD_FAST_READ 8'h0b
`define FVRC_CMD_WR_CFG    8'h81
`define FVRC_CMD_RD_CFG    8'h85

// ----------------------------------------------------------------
// Volatile read configuration fields
// ----------------------------------------------------------------
`define FVRC_DUMMY_HI      7
`define FVRC_DUMMY_LO      4
`define FVRC_XIP_BIT       3
`define FVRC_RSVD_BIT      2
`define FVRC_WRAP_HI       1
`define FVRC_WRAP_LO       0
`define FVRC_CFG_RESET     8'hfb
`define FVRC_CFG_WR_MASK   8'hfb
`define FVRC_DUMMY_DEF_A   4'h0
`define FVRC_DUMMY_DEF_B   4'hf
`define FVRC_DUMMY_DEFAULT 4'h8
`define FVRC_WRAP_16       2'h0
`define FVRC_WRAP_32       2'h1
`define FVRC_WRAP_64       2'h2
`define FVRC_MASK_16       24'h00000f
`define FVRC_MASK_32       24'h00001f
`define FVRC_MASK_64       24'h00003f
`define FVRC_MASK_SEQ      24'hffffff

// ----------------------------------------------------------------
// Controller registers (byte offsets) and reset values
// ----------------------------------------------------------------
`define FVRC_REG_CMD       8'h00
`define FVRC_REG_ADDR      8'h04
`define FVRC_REG_LEN       8'h08
`define FVRC_REG_DUMMY     8'h0c
`define FVRC_REG_WDATA     8'h10
`define FVRC_REG_STATUS    8'h14
`define FVRC_REG_RDATA     8'h18
`define FVRC_REG_RCOUNT    8'h1c
`define FVRC_CMD_XBIT      2
`define FVRC_HOST_DUMMY_RST 4'h8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FVRC_CLK_PERIOD_NS 5
`define FVRC_SCK_PERIOD_NS 160
`define FVRC_SCK_HALF_CYC  (`FVRC_SCK_PERIOD_NS / (2 * `FVRC_CLK_PERIOD_NS))

`endif

/* fvrc_pkg.sv */
// Types shared by the flash config link ends
`default_nettype none

package fvrc_pkg;

  typedef enum logic [6:0] {
    ST_CMD    = 7'h01,
    ST_ADDR   = 7'h02,
    ST_DUMMY  = 7'h04,
    ST_DATA   = 7'h08,
    ST_WRCFG  = 7'h10,
    ST_RDCFG  = 7'h20,
    ST_IGNORE = 7'h40
  } fvrc_dev_state_t;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_TX   = 5'h02,
    H_DUM  = 5'h04,
    H_RX   = 5'h08,
    H_END  = 5'h10
  } fvrc_host_state_t;

  typedef enum logic [1:0] {
    OP_WR_CFG = 2'h0,
    OP_RD_CFG = 2'h1,
    OP_READ   = 2'h2,
    OP_XIP_RD = 2'h3
  } fvrc_op_t;

endpackage : fvrc_pkg

`default_nettype wire

/* fvrc_link_if.sv */
// Serial link between the flash controller and the flash configuration end
`timescale 1ns/1ps
`default_nettype none

interface fvrc_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso_out;
  logic miso_oe;
  logic miso;

  // Data-out line is pulled up while the device does not drive it
  assign miso = miso_oe ? miso_out : 1'b1;

  modport dev (
    input  sck,
    input  cs_n,
    input  mosi,
    output miso_out,
    output miso_oe
  );

  modport host (
    output sck,
    output cs_n,
    output mosi,
    input  miso
  );
endinterface : fvrc_link_if

`default_nettype wire

/* fvrc_sync.sv */
// Two-flop synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none

module fvrc_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_q <= INIT[g];
          sync_q <= INIT[g];
        end else begin
          meta_q <= d_i[g];
          sync_q <= meta_q;
        end
      end
      assign q_o[g] = sync_q;
    end
  endgenerate

endmodule : fvrc_sync

`default_nettype wire

/* fvrc_device.sv */
// Flash end: volatile read configuration register and fast read sequencing
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fvrc_map.svh"

// Summary of operation
// RULE1 - Dummy count comes from config bits 7:4
// RULE2 - Codes 0000 and 1111 select default count
// RULE3 - Host programs enough dummy cycles for clock
// RULE4 - Bit 3 gates execute-in-place; variant ignores it
// RULE5 - Wrap code 00 wraps in 16-byte block
// RULE6 - Wrap code 01 wraps in 32-byte block
// RULE7 - Wrap code 10 wraps in 64-byte block
// RULE8 - Wrap code 11 reads sequentially, no wrap
// RULE9 - Block end returns to block first byte
// RULE10 - Written settings apply immediately on write
// RULE11 - Register reached only by dedicated commands
// RULE12 - Host respects single-rate clock per dummy count
// RULE13 - Host respects double-rate clock per dummy count
// RULE14 - Codes 0001 to 1110 give count directly
// RULE15 - Reserved bit 2 reads zero, no effect
module fvrc_device #(
  parameter logic [3:0] DEFAULT_DUMMY = `FVRC_DUMMY_DEFAULT,
  parameter bit         XIP_ALWAYS    = 1'b0
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Serial link
  fvrc_link_if.dev         link,
  // User side status
  output logic      [7:0]  cfg_o,
  output logic      [3:0]  dummy_cycles_o,
  output logic             xip_active_o,
  output logic      [23:0] rd_addr_o,
  output logic             cfg_wr_o,
  output logic             busy_o
);
  import fvrc_pkg::*;

  // ----------------------------------------------------------------
  // Link input synchronisation and edge detection
  // ----------------------------------------------------------------
  logic [2:0] lnk_s;
  logic       sck_s;
  logic       csn_s;
  logic       mosi_s;
  logic       sck_prev_q;
  logic       rise;
  logic       fall;

  fvrc_sync #(
    .W    (3),
    .INIT (3'h2)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({link.sck, link.cs_n, link.mosi}),
    .q_o   (lnk_s)
  );

  assign sck_s  = lnk_s[2];
  assign csn_s  = lnk_s[1];
  assign mosi_s = lnk_s[0];
  assign rise   = sck_s & ~sck_prev_q & ~csn_s;
  assign fall   = ~sck_s & sck_prev_q & ~csn_s;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fvrc_dev_state_t state_q;
  fvrc_dev_state_t state_d;
  logic [4:0]      cnt_q;
  logic [4:0]      cnt_d;
  logic [7:0]      sh_q;
  logic [23:0]     addr_q;
  logic [23:0]     addr_d;
  logic [3:0]      dcnt_q;
  logic [3:0]      dcnt_d;
  logic [7:0]      cfg_q;
  logic [7:0]      cfg_d;
  logic            xip_q;
  logic            xip_d;
  logic            cfg_wr_q;
  logic            cfg_wr_d;
  logic [7:0]      tx_q;
  logic            miso_q;
  logic            oe_q;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  logic [7:0]  in_byte;
  logic        byte_done;
  logic [3:0]  dummy_code;
  logic [3:0]  dummy_n;
  logic [1:0]  wrap;
  logic [23:0] wrap_mask;
  logic [23:0] addr_inc;
  logic [23:0] next_addr;
  logic        xip_en;
  logic        out_state;
  logic [7:0]  out_byte;

  assign in_byte    = {sh_q[6:0], mosi_s};
  assign byte_done  = rise & (cnt_q[2:0] == 3'h7);
  assign dummy_code = cfg_q[`FVRC_DUMMY_HI:`FVRC_DUMMY_LO];  // see RULE1
  assign dummy_n    = ((dummy_code == `FVRC_DUMMY_DEF_A) ||
                       (dummy_code == `FVRC_DUMMY_DEF_B)) ? DEFAULT_DUMMY  // see RULE2
                                                          : dummy_code;    // see RULE14
  assign wrap       = cfg_q[`FVRC_WRAP_HI:`FVRC_WRAP_LO];
  assign wrap_mask  = (wrap == `FVRC_WRAP_16) ? `FVRC_MASK_16 :   // see RULE5
                      (wrap == `FVRC_WRAP_32) ? `FVRC_MASK_32 :   // see RULE6
                      (wrap == `FVRC_WRAP_64) ? `FVRC_MASK_64 :   // see RULE7
                                                `FVRC_MASK_SEQ;   // see RULE8
  assign addr_inc   = addr_q + 24'h000001;
  // Upper bits hold, low bits roll over inside the aligned block
  assign next_addr  = (addr_q & ~wrap_mask) | (addr_inc & wrap_mask);  // see RULE9
  // Enabled when the bit is clear; some variants run it regardless
  assign xip_en     = XIP_ALWAYS | ~cfg_q[`FVRC_XIP_BIT];  // see RULE4
  assign out_state  = (state_q == ST_DATA) | (state_q == ST_RDCFG);
  // Array content is its own low address byte, enough to trace wrap order
  assign out_byte   = (state_q == ST_RDCFG) ? cfg_q : addr_q[7:0];

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    addr_d   = addr_q;
    dcnt_d   = dcnt_q;
    cfg_d    = cfg_q;
    xip_d    = xip_q;
    cfg_wr_d = 1'b0;
    if (csn_s) begin
      // In execute-in-place the next frame opens with the address
      state_d = xip_q ? ST_ADDR : ST_CMD;
      cnt_d   = 5'h00;
      dcnt_d  = 4'h0;
    end else if (rise) begin
      cnt_d = cnt_q + 5'h01;
      case (state_q)
        ST_CMD: begin
          if (byte_done) begin
            cnt_d = 5'h00;
            if (in_byte == `FVRC_CMD_FAST_READ) begin
              state_d = ST_ADDR;
            end else if (in_byte == `FVRC_CMD_WR_CFG) begin
              state_d = ST_WRCFG;  // see RULE11
            end else if (in_byte == `FVRC_CMD_RD_CFG) begin
              state_d = ST_RDCFG;  // see RULE11
            end else begin
              state_d = ST_IGNORE;
            end
          end
        end
        ST_ADDR: begin
          addr_d = {addr_q[22:0], mosi_s};
          if (cnt_q == 5'd23) begin
            cnt_d   = 5'h00;
            state_d = ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          cnt_d  = 5'h00;
          dcnt_d = dcnt_q + 4'h1;
          // First dummy bit low keeps execute-in-place for the next frame
          if (dcnt_q == 4'h0) begin
            xip_d = xip_en & ~mosi_s;  // see RULE4
          end
          if (dcnt_q == dummy_n - 4'h1) begin  // see RULE1
            dcnt_d  = 4'h0;
            state_d = ST_DATA;
          end
        end
        ST_DATA: begin
          if (byte_done) begin
            cnt_d  = 5'h00;
            addr_d = next_addr;  // see RULE9
          end
        end
        ST_RDCFG: begin
          if (byte_done) begin
            cnt_d = 5'h00;
          end
        end
        ST_WRCFG: begin
          if (byte_done) begin
            cfg_d    = in_byte & `FVRC_CFG_WR_MASK;  // see RULE15
            cfg_wr_d = 1'b1;                         // see RULE10
            state_d  = ST_IGNORE;
          end
        end
        ST_IGNORE: begin
          cnt_d = 5'h00;
        end
        default: begin
          state_d = ST_CMD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q    <= ST_CMD;
      cnt_q      <= 5'h00;
      sh_q       <= 8'h00;
      addr_q     <= 24'h000000;
      dcnt_q     <= 4'h0;
      cfg_q      <= `FVRC_CFG_RESET;
      xip_q      <= 1'b0;
      cfg_wr_q   <= 1'b0;
      sck_prev_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      sh_q       <= rise ? in_byte : sh_q;
      addr_q     <= addr_d;
      dcnt_q     <= dcnt_d;
      cfg_q      <= cfg_d;  // see RULE10
      xip_q      <= xip_d;
      cfg_wr_q   <= cfg_wr_d;
      sck_prev_q <= sck_s;
    end
  end

  // ----------------------------------------------------------------
  // Data out: changes on falling clock, first bit loaded per byte
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_q   <= 8'h00;
      miso_q <= 1'b1;
      oe_q   <= 1'b0;
    end else if (csn_s) begin
      oe_q <= 1'b0;
    end else if (fall && out_state) begin
      oe_q <= 1'b1;
      if (cnt_q[2:0] == 3'h0) begin
        miso_q <= out_byte[7];
        tx_q   <= {out_byte[6:0], 1'b0};
      end else begin
        miso_q <= tx_q[7];
        tx_q   <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.miso_out  = miso_q;
  assign link.miso_oe   = oe_q;
  assign cfg_o          = cfg_q;
  assign dummy_cycles_o = dummy_n;
  assign xip_active_o   = xip_q;
  assign rd_addr_o      = addr_q;
  assign cfg_wr_o       = cfg_wr_q;
  assign busy_o         = ~csn_s;

endmodule : fvrc_device

`default_nettype wire

/* fvrc_host.sv */
// Controller end: Wishbone registers driving the serial flash link
`timescale 1ns/1ps
`default_nettype none
`include "fvrc_map.svh"

module fvrc_host #(
  parameter int SCK_HALF = `FVRC_SCK_HALF_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Serial link
  fvrc_link_if.host        link,
  // Status
  output logic             busy_o
);
  import fvrc_pkg::*;

  // ----------------------------------------------------------------
  // Registers and link state
  // ----------------------------------------------------------------
  fvrc_host_state_t hst_q;
  logic [23:0] addr_q;
  logic [7:0]  len_q;
  logic [3:0]  dum_q;
  logic [7:0]  wdat_q;
  logic [7:0]  rdat_q;
  logic [7:0]  rcnt_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic [7:0]  div_q;
  logic        sck_q;
  logic        csn_q;
  logic        mosi_q;
  logic        xbit_q;
  logic [31:0] txsh_q;
  logic [10:0] txn_q;
  logic [10:0] dn_q;
  logic [10:0] rxn_q;
  logic [10:0] cnt_q;
  logic [7:0]  rx_q;
  logic        miso_s;

  fvrc_sync #(
    .W    (1),
    .INIT (1'b1)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (link.miso),
    .q_o   (miso_s)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        req;
  logic        wr_en;
  logic [31:0] wmask;
  logic [31:0] rd_mux;
  logic        go;
  fvrc_op_t    op;
  logic [31:0] ld_txsh;
  logic [10:0] ld_txn;
  logic [10:0] ld_dn;
  logic [10:0] ld_rxn;
  logic        tick;

  assign req   = wb_cyc_i & wb_stb_i;
  assign wr_en = req & wb_we_i & ack_q;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign rd_mux = (wb_adr_i == `FVRC_REG_ADDR)   ? {8'h00, addr_q} :
                  (wb_adr_i == `FVRC_REG_LEN)    ? {24'h0, len_q} :
                  (wb_adr_i == `FVRC_REG_DUMMY)  ? {28'h0, dum_q} :
                  (wb_adr_i == `FVRC_REG_WDATA)  ? {24'h0, wdat_q} :
                  (wb_adr_i == `FVRC_REG_STATUS) ? {31'h0, busy_o} :
                  (wb_adr_i == `FVRC_REG_RDATA)  ? {24'h0, rdat_q} :
                  (wb_adr_i == `FVRC_REG_RCOUNT) ? {24'h0, rcnt_q} : 32'h0;
  // A command written while a frame runs is dropped
  assign go    = wr_en & (wb_adr_i == `FVRC_REG_CMD) & wb_sel_i[0] & (hst_q == H_IDLE);
  assign op    = fvrc_op_t'(wb_dat_i[1:0]);
  // Only the two dedicated commands reach the device register
  assign ld_txsh = (op == OP_WR_CFG) ? {`FVRC_CMD_WR_CFG, wdat_q, 16'h0000} :  // see RULE11
                   (op == OP_RD_CFG) ? {`FVRC_CMD_RD_CFG, 24'h000000} :        // see RULE11
                   (op == OP_READ)   ? {`FVRC_CMD_FAST_READ, addr_q} :
                                       {addr_q, 8'h00};
  assign ld_txn  = (op == OP_WR_CFG) ? 11'd16 : (op == OP_RD_CFG) ? 11'd8 :
                   (op == OP_READ)   ? 11'd32 : 11'd24;
  // Software must set this to the count the device applies
  assign ld_dn   = (op[1]) ? {7'h00, dum_q} : 11'h000;  // see RULE3
  assign ld_rxn  = (op == OP_WR_CFG) ? 11'h000 : (op == OP_RD_CFG) ? 11'd8 : {len_q, 3'h0};
  assign tick    = (div_q == 8'(SCK_HALF - 1));

  // ----------------------------------------------------------------
  // Wishbone registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      dat_q  <= 32'h0;
      addr_q <= 24'h000000;
      len_q  <= 8'h00;
      dum_q  <= `FVRC_HOST_DUMMY_RST;
      wdat_q <= 8'h00;
    end else begin
      ack_q <= req & ~ack_q;
      dat_q <= (req & ~ack_q) ? rd_mux : dat_q;
      if (wr_en && wb_adr_i == `FVRC_REG_ADDR) begin
        addr_q <= (addr_q & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
      end
      if (wr_en && wb_adr_i == `FVRC_REG_LEN && wb_sel_i[0]) begin
        len_q <= wb_dat_i[7:0];
      end
      if (wr_en && wb_adr_i == `FVRC_REG_DUMMY && wb_sel_i[0]) begin
        dum_q <= wb_dat_i[3:0];
      end
      if (wr_en && wb_adr_i == `FVRC_REG_WDATA && wb_sel_i[0]) begin
        wdat_q <= wb_dat_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Link engine: mode 0, sample on rising, shift on falling
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hst_q <= H_IDLE;
      div_q <= 8'h00;
      sck_q <= 1'b0;
      csn_q <= 1'b1;
      mosi_q <= 1'b0;
      xbit_q <= 1'b0;
      txsh_q <= 32'h0;
      txn_q <= 11'h000;
      dn_q <= 11'h000;
      rxn_q <= 11'h000;
      cnt_q <= 11'h000;
      rx_q <= 8'h00;
      rdat_q <= 8'h00;
      rcnt_q <= 8'h00;
    end else if (hst_q == H_IDLE) begin
      if (go) begin
        hst_q  <= H_TX;
        div_q  <= 8'h00;
        csn_q  <= 1'b0;
        txsh_q <= ld_txsh;
        mosi_q <= ld_txsh[31];
        xbit_q <= wb_dat_i[`FVRC_CMD_XBIT];
        txn_q  <= ld_txn;
        dn_q   <= ld_dn;
        rxn_q  <= ld_rxn;
        cnt_q  <= 11'h000;
        rcnt_q <= 8'h00;
      end
    end else begin
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      if (tick) begin
        if (hst_q == H_END && csn_q) begin
          // Deselect held a full half period before the next frame
          hst_q <= H_IDLE;
        end else if (!sck_q) begin
          sck_q <= 1'b1;
          cnt_q <= cnt_q + 11'h001;
          case (hst_q)
            H_TX: begin
              txsh_q <= {txsh_q[30:0], 1'b0};
              if (cnt_q == txn_q - 11'h001) begin
                cnt_q <= 11'h000;
                hst_q <= (dn_q != 11'h000) ? H_DUM : (rxn_q != 11'h000) ? H_RX : H_END;
              end
            end
            H_DUM: begin
              if (cnt_q == dn_q - 11'h001) begin
                cnt_q <= 11'h000;
                hst_q <= (rxn_q != 11'h000) ? H_RX : H_END;
              end
            end
            H_RX: begin
              rx_q <= {rx_q[6:0], miso_s};
              if (cnt_q[2:0] == 3'h7) begin
                rdat_q <= {rx_q[6:0], miso_s};
                rcnt_q <= rcnt_q + 8'h01;
              end
              if (cnt_q == rxn_q - 11'h001) begin
                hst_q <= H_END;
              end
            end
            default: begin
            end
          endcase
        end else begin
          sck_q  <= 1'b0;
          mosi_q <= (hst_q == H_TX) ? txsh_q[31] : xbit_q;
          csn_q  <= (hst_q == H_END);
        end
      end
    end
  end

  assign link.sck  = sck_q;
  assign link.cs_n = csn_q;
  assign link.mosi = mosi_q;
  assign wb_dat_o  = dat_q;
  assign wb_ack_o  = ack_q;
  assign busy_o    = (hst_q != H_IDLE);

endmodule : fvrc_host

`default_nettype wire

/* fvrc_monitor.sv */
// Link checker for the flash configuration serial interface
`timescale 1ns/1ps
`default_nettype none

module fvrc_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link signals
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic miso
);
  logic       sck_q;
  logic [7:0] rise_q;
  logic [7:0] rise_d;

  // Saturating count of serial clock rises within a frame
  assign rise_d = cs_n ? 8'h00 : (sck && !sck_q && rise_q != 8'hff) ? rise_q + 8'h01 : rise_q;

  always_ff @(posedge clk_i) begin
    sck_q  <= rst_i ? 1'b0 : sck;
    rise_q <= rst_i ? 8'h00 : rise_d;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence gap_s;
    cs_n [*4];
  endsequence

  sequence quiet_s;
    cs_n [*8];
  endsequence

  idle_sck_a: assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("serial clock not idle low outside frame");
  cs_gap_a: assert property ($rose(cs_n) |-> gap_s)
    else $error("select high gap too short");
  oe_release_a: assert property ($rose(cs_n) |-> ##[1:6] !miso_oe)
    else $error("data out not released after frame");
  oe_idle_a: assert property (quiet_s |-> !miso_oe)
    else $error("data out driven while deselected");
  oe_start_a: assert property ($rose(miso_oe) |-> !cs_n && !sck)
    else $error("data out started outside a low clock phase");
  oe_count_a: assert property ($rose(miso_oe) |->
      rise_q == 8'h08 || (rise_q >= 8'h19 && rise_q <= 8'h2e))
    else $error("data out started after wrong clock count");
  bit_stable_a: assert property (miso_oe && $past(miso_oe) && sck && $past(sck)
      |-> $stable(miso_out))
    else $error("data out changed while clock high");
  mosi_stable_a: assert property (!cs_n && sck && $past(sck) |-> $stable(mosi))
    else $error("data in changed while clock high");
  sck_rate_a: assert property ($changed(sck) |=> $stable(sck) [*3])
    else $error("serial clock level held too briefly");
  line_idle_a: assert property (!miso_oe |-> miso)
    else $error("data line not pulled up while released");
endmodule : fvrc_monitor

`default_nettype wire

/* tb_flash_volatile_read_config.sv */
// Bench joining the controller and flash configuration ends
`timescale 1ns/1ps
`default_nettype none
`include "fvrc_map.svh"

module tb_flash_volatile_read_config;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack;
  logic [7:0]  cfg_o;
  logic [3:0]  dummy_cycles_o;
  logic        xip_active_o;
  logic [3:0]  d;
  logic [23:0] rd_addr;
  logic        cfg_wr;
  logic        dbusy;
  int          n_wr = 0;
  logic [31:0] wexp [0:3] = '{32'h31, 32'h21, 32'h01, 32'h41};
  logic [23:0] wadr [0:3] = '{24'h000132, 24'h000122, 24'h000102, 24'h000142};
  logic [3:0]  codes [0:4] = '{4'h0, 4'h1, 4'h3, 4'he, 4'hf};
  int          n_fail;
  int          n_checks;

  fvrc_link_if lnk ();
  // Divider of 8 keeps the link clock far under both rate tables
  fvrc_host #(.SCK_HALF(8)) i_fvrc_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .link(lnk.host), .busy_o());
  fvrc_device i_fvrc_device (.clk_i(clk_i), .rst_i(rst_i), .link(lnk.dev), .cfg_o(cfg_o),
    .dummy_cycles_o(dummy_cycles_o), .xip_active_o(xip_active_o), .rd_addr_o(rd_addr),
    .cfg_wr_o(cfg_wr), .busy_o(dbusy));
  fvrc_monitor i_fvrc_monitor (.clk_i(clk_i), .rst_i(rst_i), .sck(lnk.sck), .cs_n(lnk.cs_n),
    .mosi(lnk.mosi), .miso_out(lnk.miso_out), .miso_oe(lnk.miso_oe), .miso(lnk.miso));

  // Counts write strobes so each config write is seen exactly once
  always @(posedge clk_i) begin
    if (cfg_wr === 1'b1) n_wr++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask : chk

  // Edge first, so a release and the next request never share a time step
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    int n;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= dat;
    for (n = 0; n < 64 && ack !== 1'b1; n++) @(posedge clk_i);
    if (n == 64) begin
      n_fail++;
      final_report;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic cmd(input logic [31:0] op);
    int n;
    wb(1'b1, `FVRC_REG_CMD, op);
    for (n = 0; n < 3000; n++) begin
      wb(1'b0, `FVRC_REG_STATUS, 32'h0);
      if (q[0] === 1'b0) break;
    end
    if (n == 3000) begin
      n_fail++;
      final_report;
    end
    chk("dev_busy", 32'h0, {31'h0, dbusy});
  endtask : cmd

  task automatic cfg(input logic [7:0] v);
    int k;
    wb(1'b1, `FVRC_REG_WDATA, {24'h0, v});
    k = n_wr;
    cmd(32'h0);
    chk("cfg_o", {24'h0, v & 8'hfb}, {24'h0, cfg_o});
    chk("cfg_wr", k + 1, n_wr);
    cmd(32'h1);
    wb(1'b0, `FVRC_REG_RDATA, 32'h0);
    chk("rd_cfg", {24'h0, v & 8'hfb}, q);
  endtask : cfg

  task automatic rd(input logic [31:0] op, input logic [23:0] a, input logic [7:0] n,
                    input logic [3:0] dc);
    wb(1'b1, `FVRC_REG_ADDR, {8'h0, a});
    wb(1'b1, `FVRC_REG_LEN, {24'h0, n});
    wb(1'b1, `FVRC_REG_DUMMY, {28'h0, dc});
    cmd(op);
    wb(1'b0, `FVRC_REG_RCOUNT, 32'h0);
    chk("rcount", {24'h0, n}, q);
    wb(1'b0, `FVRC_REG_RDATA, 32'h0);
  endtask : rd

  // ----------------------------------------------------------------
  // Clock and sequence
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    n_fail = 0;
    n_checks = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("cfg_rst", 32'hfb, {24'h0, cfg_o});
    wb(1'b1, 8'h20, 32'h5a);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    foreach (codes[i]) begin
      cfg({codes[i], 4'hb});
      d = (codes[i] == 4'h0 || codes[i] == 4'hf) ? 4'h8 : codes[i];
      chk("dummy", {28'h0, d}, {28'h0, dummy_cycles_o});
      rd(32'h2, 24'h0000fe, 8'h3, d);
      chk("seq_data", 32'h0, q);
      chk("xip_off", 32'h0, {31'h0, xip_active_o});
    end
    cfg(8'h3f);
    rd(32'h2, 24'h000020, 8'h1, 4'h3);
    chk("rsvd_data", 32'h20, q);
    for (int w = 0; w < 4; w++) begin
      cfg({4'h5, 2'b10, w[1:0]});
      rd(32'h2, 24'h00013e, 8'h4, 4'h5);
      chk("wrap", wexp[w], q);
      chk("wrap_adr", {8'h0, wadr[w]}, {8'h0, rd_addr});
    end
    cfg(8'h53);
    rd(32'h2, 24'h000200, 8'h2, 4'h5);
    chk("xip_on", 32'h1, {31'h0, xip_active_o});
    rd(32'h3, 24'h000310, 8'h2, 4'h5);
    chk("xip_data", 32'h11, q);
    rd(32'h7, 24'h000400, 8'h1, 4'h5);
    chk("xip_exit", 32'h0, {31'h0, xip_active_o});
    cfg(8'hfb);
    // Address-first frame outside execute-in-place: unknown command, line stays pulled up
    rd(32'h3, 24'h5a0000, 8'h1, 4'h5);
    chk("ign_data", 32'hff, q);
    chk("cfg_kept", 32'hfb, {24'h0, cfg_o});
    final_report;
  end
endmodule : tb_flash_volatile_read_config

`default_nettype wire
